// ==== rtl/psnc_core.sv ====
// Purpose: power state and nvm control of a sensorless motor driver
// Assumes: register port on the core clock, speed pin from outside
// Notes: analog speed arrives as a code already on the core clock
//
// Behaviour
// - peak duty is largest per electrical cycle
// - amplitude scales linearly with peak duty
// - low power stops driving all phases
// - sleep stops regulator, port, resets registers
// - standby keeps regulator, registers and port
// - inhibit bit blocks low power entry
// - inhibit does not end low power
// - status bit six shows low power
// - analog mode qualifies entry and exit
// - sleep exit needs higher analog level
// - pwm mode qualifies pin low and high; sleep entry clears mode to analog, so sleep exit uses analog level
// - serial mode qualifies zero speed command
// - sleep exit in serial uses speed pin, or analog level when wake analog bit set; sleep entry clears config to analog mode, so exit uses analog level
// - ninety six bits of parameter storage
// - programming takes 24 ms, go self clears
// - resistance and bemf codes in param registers
// - resistance decodes as mantissa shifted by exponent
// - largest code decodes to 1920
// - storage copied to registers after reset, sleep
// - host written registers govern operation
// - bemf code decodes the same way
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module psnc_core #(
    parameter int NVM_PROG_CYCLES = psnc_pkg::T_NVM_PROG_US * psnc_pkg::CORE_CLK_MHZ
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // speed inputs
    input wire logic i_speed_pin,
    input wire logic [9:0] i_speed_analog,
    input wire logic i_sleep_variant,
    // modulation
    input wire logic i_duty_valid,
    input wire logic [8:0] i_duty_sample,
    input wire logic i_elec_cycle_start,
    input wire logic [11:0] i_vcc_code,
    output logic [8:0] o_peak_duty_output,
    output logic [11:0] o_amplitude,
    // power and drive
    output logic o_phase_drive_en,
    output logic o_buck_enable,
    output logic o_serial_port_active,
    output logic o_low_power,
    // motor parameters
    output logic [10:0] o_phase_res_linear,
    output logic [10:0] o_bemf_linear,
    output logic o_nvm_busy
);
    import psnc_pkg::*;

    // decode a 7-bit code: mantissa shifted by exponent
    function automatic logic [10:0] decode_code(input logic [6:0] code);
        logic [10:0] mant;
        mant = {7'h00, code[CODE_MANT_MSB:0]};
        decode_code = mant << code[6:CODE_EXP_LSB];
    endfunction

    localparam int PROG_W = $clog2(NVM_PROG_CYCLES + 1);

    // elaboration check on programming time
    if (NVM_PROG_CYCLES < 1) begin : g_bad_prog
        $error("programming time must be at least one cycle");
    end

    logic speed_meta;
    logic speed_sync;
    logic variant_meta;
    logic sleep_variant;
    logic [8:0] speed_command_field;
    logic [7:0] device_control_reg;
    logic [7:0] nvm_control_reg;
    logic [7:0] config_reg;
    logic [7:0] param_reg [PARAM_BYTES];
    logic [7:0] nvm_mem [PARAM_BYTES];
    logic [8:0] running_max;
    logic [PROG_W-1:0] prog_count;
    logic reload;
    psnc_lp_t lp_state;
    psnc_mode_t mode;
    logic port_on;
    logic low_power_inhibit;
    logic enter_cond;
    logic exit_cond;
    logic [QUAL_W-1:0] enter_limit;
    logic [QUAL_W-1:0] exit_limit;
    logic enter_done;
    logic exit_done;
    logic sleep_reset;
    logic wr_ok;
    logic param_hit;
    logic [3:0] param_idx;
    logic [8:0] next_max;
    logic [8:0] duty_clamped;
    logic [20:0] amp_product;

    // two flip-flop synchronisers for pin inputs
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            speed_meta <= 1'b0;
            speed_sync <= 1'b0;
            variant_meta <= 1'b0;
            sleep_variant <= 1'b0;
        end else begin
            speed_meta <= i_speed_pin;
            speed_sync <= speed_meta;
            variant_meta <= i_sleep_variant;
            sleep_variant <= variant_meta;
        end
    end

    // decoded control fields
    always_comb begin
        mode = psnc_mode_t'(config_reg[CFG_MODE_LSB +: 2]);
        low_power_inhibit = config_reg[CFG_INHIBIT_BIT];
        param_idx = i_addr[3:0];
        param_hit = (i_addr >= REG_PARAM_FIRST) && (i_addr <= REG_PARAM_LAST);
        port_on = !(o_low_power && sleep_variant);
        wr_ok = i_wr && port_on;
    end

    // entry and exit conditions per speed command mode
    always_comb begin
        enter_cond = 1'b0;
        exit_cond = 1'b0;
        enter_limit = EN_PWM_CYC;
        exit_limit = EX_PWM_CYC;
        case (mode)
            MODE_ANALOG: begin
                enter_limit = EN_ANA_CYC;
                exit_limit = EX_ANA_CYC;
                enter_cond = i_speed_analog < (sleep_variant ? ANA_EN_SL : ANA_EN_SB);
                exit_cond = i_speed_analog > (sleep_variant ? ANA_EX_SL : ANA_EX_SB);
            end
            MODE_PWM: begin
                enter_cond = !speed_sync;
                exit_cond = speed_sync;
            end
            MODE_SERIAL: begin
                enter_cond = (speed_command_field == SPEED_RESET);
                if (sleep_variant) begin
                    exit_cond = config_reg[CFG_WAKE_ANALOG_BIT] ?
                        (i_speed_analog > ANA_EX_SL) : speed_sync;
                    exit_limit = config_reg[CFG_WAKE_ANALOG_BIT] ? EX_ANA_CYC : EX_PWM_CYC;
                end else begin
                    exit_cond = (speed_command_field != SPEED_RESET);
                end
            end
            default: begin
                enter_cond = 1'b0;
                exit_cond = 1'b0;
            end
        endcase
    end

    psnc_qual_timer #(
        .WIDTH(QUAL_W)
    ) u_enter_timer (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_cond(enter_cond && (lp_state == LP_RUN)),
        .i_limit(enter_limit),
        .o_done(enter_done)
    );

    psnc_qual_timer #(
        .WIDTH(QUAL_W)
    ) u_exit_timer (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_cond(exit_cond && (lp_state == LP_LOW)),
        .i_limit(exit_limit),
        .o_done(exit_done)
    );

    // low power state machine
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            lp_state <= LP_RUN;
        end else begin
            case (lp_state)
                LP_RUN: begin
                    if (enter_done && !low_power_inhibit && !o_nvm_busy) begin
                        lp_state <= LP_LOW;
                    end
                end
                LP_LOW: begin
                    if (exit_done) begin
                        lp_state <= LP_RUN;
                    end
                end
                default: lp_state <= LP_RUN;
            endcase
        end
    end

    // one-cycle pulse that clears volatile registers on sleep entry
    always_comb begin
        sleep_reset = (lp_state == LP_RUN) && enter_done && !low_power_inhibit &&
            !o_nvm_busy && sleep_variant;
    end

    // reload of parameters after reset and after leaving sleep
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            reload <= 1'b1;
        end else begin
            reload <= (lp_state == LP_LOW) && exit_done && sleep_variant;
        end
    end

    // power and drive outputs
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_low_power <= 1'b0;
            o_phase_drive_en <= 1'b0;
            o_buck_enable <= 1'b1;
            o_serial_port_active <= 1'b1;
        end else begin
            o_low_power <= (lp_state == LP_LOW);
            o_phase_drive_en <= (lp_state == LP_RUN);
            o_buck_enable <= !((lp_state == LP_LOW) && sleep_variant);
            o_serial_port_active <= !((lp_state == LP_LOW) && sleep_variant);
        end
    end

    // volatile control registers
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn || sleep_reset) begin
            speed_command_field <= SPEED_RESET;
            device_control_reg <= 8'h00;
            config_reg <= CONFIG_RESET;
        end else if (wr_ok) begin
            if (i_addr == REG_SPEED_LO) begin
                speed_command_field[7:0] <= i_wdata;
            end
            if (i_addr == REG_SPEED_HI) begin
                speed_command_field[8] <= i_wdata[0];
            end
            if (i_addr == REG_DEVICE_CONTROL) begin
                device_control_reg <= i_wdata;
            end
            if (i_addr == REG_CONFIG) begin
                config_reg <= {4'h0, i_wdata[3:0]};
            end
        end
    end

    // nvm control register and programming sequence
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn || sleep_reset) begin
            nvm_control_reg <= NVM_RESET;
            prog_count <= '0;
        end else if (prog_count != '0) begin
            prog_count <= prog_count - PROG_W'(1);
            if (prog_count == PROG_W'(1)) begin
                nvm_control_reg[NVM_GO_BIT] <= 1'b0;
            end
        end else if (wr_ok && (i_addr == REG_NVM_CONTROL)) begin
            nvm_control_reg[NVM_LOAD_SEL_BIT] <= i_wdata[NVM_LOAD_SEL_BIT];
            if (i_wdata[NVM_GO_BIT] && nvm_control_reg[NVM_LOAD_SEL_BIT] &&
                (device_control_reg == PROGRAM_UNLOCK_KEY)) begin
                nvm_control_reg[NVM_GO_BIT] <= 1'b1;
                prog_count <= PROG_W'(NVM_PROG_CYCLES);
            end
        end
    end

    // busy flag from the programming counter
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_nvm_busy <= 1'b0;
        end else begin
            o_nvm_busy <= (prog_count > PROG_W'(1));
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            for (int i = 0; i < PARAM_BYTES; i++) begin
                nvm_mem[i] <= 8'h00;
            end
        end else if (prog_count == PROG_W'(1)) begin
            for (int i = 0; i < PARAM_BYTES; i++) begin
                nvm_mem[i] <= param_reg[i];
            end
        end
    end

    // parameter registers: reload from store, host writes take over
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            for (int i = 0; i < PARAM_BYTES; i++) begin
                param_reg[i] <= 8'h00;
            end
        end else if (reload) begin
            for (int i = 0; i < PARAM_BYTES; i++) begin
                param_reg[i] <= nvm_mem[i];
            end
        end else if (wr_ok && param_hit && (prog_count == '0)) begin
            param_reg[param_idx] <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_phase_res_linear <= 11'h000;
            o_bemf_linear <= 11'h000;
        end else begin
            o_phase_res_linear <= decode_code(param_reg[REG_PARAM_A[3:0]][6:0]);
            o_bemf_linear <= decode_code(param_reg[REG_PARAM_B[3:0]][6:0]);
        end
    end

    // clamp duty samples to full scale and track the maximum
    always_comb begin
        duty_clamped = (i_duty_sample > DUTY_FULL) ? DUTY_FULL : i_duty_sample;
        next_max = running_max;
        if (i_duty_valid && (duty_clamped > running_max)) begin
            next_max = duty_clamped;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            running_max <= 9'h000;
            o_peak_duty_output <= 9'h000;
        end else if (i_elec_cycle_start) begin
            o_peak_duty_output <= next_max;
            running_max <= i_duty_valid ? duty_clamped : 9'h000;
        end else begin
            running_max <= next_max;
        end
    end

    always_comb begin
        amp_product = {9'h000, i_vcc_code} * {12'h000, o_peak_duty_output};
    end

    // amplitude register
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_amplitude <= 12'h000;
        end else begin
            o_amplitude <= amp_product[DUTY_SHIFT +: 12];
        end
    end

    // read data one cycle after the strobe, zero when port is off
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd && port_on) begin
            if (param_hit) begin
                o_rdata <= param_reg[param_idx];
            end else begin
                case (i_addr)
                    REG_SPEED_LO: o_rdata <= speed_command_field[7:0];
                    REG_SPEED_HI: o_rdata <= {7'h00, speed_command_field[8]};
                    REG_DEVICE_CONTROL: o_rdata <= device_control_reg;
                    REG_NVM_CONTROL: o_rdata <= nvm_control_reg;
                    REG_CONFIG: o_rdata <= config_reg;
                    REG_STATUS: o_rdata <= {1'b0, o_low_power, 6'h00};
                    default: o_rdata <= 8'h00;
                endcase
            end
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/psnc_pkg.sv ====
// Purpose: shared constants for the power state and nvm control block
// Assumes: 8-bit register port, core clock of 40 MHz
// Notes: thresholds and qualification times are plain defaults
package psnc_pkg;
    // core clock rate
    localparam int CORE_CLK_MHZ = 40;
    // register offsets
    localparam logic [7:0] REG_SPEED_LO = 8'h00;
    localparam logic [7:0] REG_SPEED_HI = 8'h01;
    localparam logic [7:0] REG_DEVICE_CONTROL = 8'h03;
    localparam logic [7:0] REG_NVM_CONTROL = 8'h0a;
    localparam logic [7:0] REG_CONFIG = 8'h0b;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_PARAM_FIRST = 8'h20;
    localparam logic [7:0] REG_PARAM_LAST = 8'h2b;
    localparam logic [7:0] REG_PARAM_A = 8'h20;
    localparam logic [7:0] REG_PARAM_B = 8'h21;
    localparam int PARAM_BYTES = 12;
    // field positions
    localparam int NVM_GO_BIT = 0;
    localparam int NVM_LOAD_SEL_BIT = 1;
    localparam int CFG_INHIBIT_BIT = 0;
    localparam int CFG_MODE_LSB = 1;
    localparam int CFG_WAKE_ANALOG_BIT = 3;
    localparam int STATUS_LOW_POWER_BIT = 6;
    localparam int CODE_MANT_MSB = 3;
    localparam int CODE_EXP_LSB = 4;
    // reset values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] NVM_RESET = 8'h00;
    localparam logic [8:0] SPEED_RESET = 9'h000;
    // programming unlock key
    localparam logic [7:0] PROGRAM_UNLOCK_KEY = 8'hb6;
    // duty full scale: 0x100 is 100 percent
    localparam logic [8:0] DUTY_FULL = 9'h100;
    localparam int DUTY_SHIFT = 8;
    // analog thresholds on a 10-bit speed code
    localparam logic [9:0] ANA_EN_SB = 10'h020;
    localparam logic [9:0] ANA_EN_SL = 10'h020;
    localparam logic [9:0] ANA_EX_SB = 10'h030;
    localparam logic [9:0] ANA_EX_SL = 10'h060;
    // qualification times in microseconds, and derived cycle counts
    localparam int T_EN_ANA_US = 50;
    localparam int T_EX_ANA_US = 20;
    localparam int T_EN_PWM_US = 60;
    localparam int T_EX_PWM_US = 20;
    localparam int QUAL_W = 13;
    localparam logic [QUAL_W-1:0] EN_ANA_CYC = QUAL_W'(T_EN_ANA_US * CORE_CLK_MHZ);
    localparam logic [QUAL_W-1:0] EX_ANA_CYC = QUAL_W'(T_EX_ANA_US * CORE_CLK_MHZ);
    localparam logic [QUAL_W-1:0] EN_PWM_CYC = QUAL_W'(T_EN_PWM_US * CORE_CLK_MHZ);
    localparam logic [QUAL_W-1:0] EX_PWM_CYC = QUAL_W'(T_EX_PWM_US * CORE_CLK_MHZ);
    // nvm programming time
    localparam int T_NVM_PROG_US = 24000;
    // speed command modes
    typedef enum logic [1:0] {
        MODE_ANALOG = 2'h0,
        MODE_PWM = 2'h1,
        MODE_SERIAL = 2'h2
    } psnc_mode_t;
    // low power states
    typedef enum logic {
        LP_RUN,
        LP_LOW
    } psnc_lp_t;
endpackage

// ==== rtl/psnc_qual_timer.sv ====
// Purpose: counts how long a condition has held without a break
// Assumes: condition is already in the core clock domain
// Notes: o_done is a level while the count has reached the limit
`timescale 1ns/1ps
`default_nettype none
module psnc_qual_timer #(
    parameter int WIDTH = 13
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // condition and limit
    input wire logic i_cond,
    input wire logic [WIDTH-1:0] i_limit,
    // result
    output logic o_done
);
    logic [WIDTH-1:0] count;

    // elaboration check on width
    if (WIDTH < 2) begin : g_bad_width
        $error("qualification timer width too small");
    end

    // count while the condition holds, restart on any break
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn || !i_cond) begin
            count <= '0;
        end else if (count != i_limit) begin
            count <= count + WIDTH'(1);
        end
    end

    // done once the condition has held for the limit
    always_comb begin
        o_done = i_cond && (count == i_limit);
    end
endmodule
`default_nettype wire

// ==== sim/psnc_core_assertions.sv ====
// Purpose: port-level checks of the power state and nvm control block
// Assumes: single core clock domain, synchronous active-low reset
// Notes: programming length is checked through a helper counter
`timescale 1ns/1ps
`default_nettype none
module psnc_core_assertions #(
    parameter int NVM_PROG_CYCLES = 960000
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // modulation
    input wire logic [11:0] i_vcc_code,
    input wire logic [8:0] o_peak_duty_output,
    input wire logic [11:0] o_amplitude,
    // power, drive and parameters
    input wire logic o_phase_drive_en,
    input wire logic o_buck_enable,
    input wire logic o_serial_port_active,
    input wire logic o_low_power,
    input wire logic [10:0] o_phase_res_linear,
    input wire logic [10:0] o_bemf_linear,
    input wire logic o_nvm_busy
);
    int busy_cnt;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    // counts cycles of one programming run
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn || !o_nvm_busy) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    a_low_no_drive: assert property (o_low_power |-> !o_phase_drive_en)
        else $error("phases driven in low power");
    a_buck_port_pair: assert property (o_buck_enable == o_serial_port_active)
        else $error("regulator and port disagree");
    a_port_off_low: assert property (!o_serial_port_active |-> o_low_power)
        else $error("port off outside low power");
    a_status_read: assert property ((i_rd && i_addr == 8'h10 && o_serial_port_active)
        ##1 $stable(o_low_power) |-> o_rdata == {1'b0, o_low_power, 6'h00})
        else $error("status read wrong");
    a_sleep_rd_zero: assert property ((i_rd && !o_serial_port_active)
        ##1 !o_serial_port_active |-> o_rdata == 8'h00)
        else $error("read answered in sleep");
    a_res_range: assert property (o_phase_res_linear <= 11'd1920)
        else $error("resistance out of range");
    a_bemf_range: assert property (o_bemf_linear <= 11'd1920)
        else $error("bemf out of range");
    a_peak_clamp: assert property (o_peak_duty_output <= 9'h100)
        else $error("peak duty above full");
    a_amp_scale: assert property (o_amplitude == 12'(({9'h0, $past(i_vcc_code)}
        * {12'h0, $past(o_peak_duty_output)}) >> 8))
        else $error("amplitude not scaled");
    a_prog_bound: assert property (o_nvm_busy |-> busy_cnt < NVM_PROG_CYCLES + 2)
        else $error("programming too long");
    a_prog_len: assert property ($fell(o_nvm_busy) |->
        $past(busy_cnt) >= NVM_PROG_CYCLES - 2)
        else $error("programming too short");
    // main scenarios reached
    cover property ($rose(o_low_power));
    cover property ($fell(o_nvm_busy));
    cover property (!o_serial_port_active ##1 o_serial_port_active);
endmodule
bind psnc_core psnc_core_assertions #(.NVM_PROG_CYCLES(NVM_PROG_CYCLES)) i_chk (
    .i_core_clk, .i_resetn, .i_addr, .i_rd, .o_rdata, .i_vcc_code,
    .o_peak_duty_output, .o_amplitude, .o_phase_drive_en, .o_buck_enable,
    .o_serial_port_active, .o_low_power, .o_phase_res_linear, .o_bemf_linear,
    .o_nvm_busy
);
`default_nettype wire

// ==== sim/psnc_speed_src.sv ====
// Purpose: host side of the speed pin
// Assumes: pin is sampled asynchronously by the block
// Notes: 200 ns square wave while running, else a held level
`timescale 1ns/1ps
`default_nettype none
module psnc_speed_src (
    // control from the bench
    input wire logic i_run,
    input wire logic i_level,
    // speed pin
    output logic o_pin
);
    logic tick = 1'b0;
    // free-running wave, phase unrelated to the core clock
    initial begin
        #37;
        forever #100 tick = ~tick;
    end
    // wave while running keeps the pin from ever settling
    assign o_pin = i_run ? tick : i_level;
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: self-checking bench of the power state and nvm control block
// Assumes: programming shortened to 20 cycles
// Notes: reads are checked from a queue of expected data
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import psnc_pkg::*;
    logic clk, rstn, wr, rd, run, lvl, dv, ecs, slp, pin, drv, buck, port, lp, busy, rd_d;
    logic [7:0] addr, wdata, rdata;
    logic [7:0] rq[$];
    logic [9:0] ana;
    logic [8:0] ds, peak;
    logic [11:0] vcc, amp;
    logic [10:0] res_lin, bemf_lin;
    logic [31:0] seed = 32'h136a;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    psnc_core #(.NVM_PROG_CYCLES(20)) i_psnc_core (
        .i_core_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_speed_pin(pin),
        .i_speed_analog(ana), .i_sleep_variant(slp), .i_duty_valid(dv),
        .i_duty_sample(ds), .i_elec_cycle_start(ecs), .i_vcc_code(vcc),
        .o_peak_duty_output(peak), .o_amplitude(amp), .o_phase_drive_en(drv),
        .o_buck_enable(buck), .o_serial_port_active(port), .o_low_power(lp),
        .o_phase_res_linear(res_lin), .o_bemf_linear(bemf_lin), .o_nvm_busy(busy)
    );
    psnc_speed_src i_psnc_speed_src (.i_run(run), .i_level(lvl), .o_pin(pin));
    // core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [10:0] dec(input logic [6:0] c);
        return 11'({7'h0, c[3:0]} << c[6:4]);
    endfunction
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // idle edge so a following strobe is never assigned twice in one step
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        rq.push_back(exp);
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_lp(input logic v, input int lim);
        int n;
        n = 0;
        while (lp !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk(lp, v);
    endtask
    task automatic ecycle(input logic [8:0] top);
        logic [8:0] cap;
        cap = (top > 9'h100) ? 9'h100 : top;
        ecs <= 1'b1;
        @(posedge clk);
        ecs <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            seed = lfsr_next(seed);
            ds <= seed[8:0] & 9'h07f;
            dv <= 1'b1;
            @(posedge clk);
        end
        ds <= top;
        @(posedge clk);
        dv <= 1'b0;
        ecs <= 1'b1;
        @(posedge clk);
        ecs <= 1'b0;
        repeat (3) @(posedge clk);
        chk(peak, cap);
        chk(amp, 12'(({9'h0, vcc} * {12'h0, cap}) >> 8));
    endtask
    // read data checked the cycle after each read strobe
    always @(posedge clk) begin
        if (rd_d) begin
            chk(rdata, rq.pop_front());
        end
        rd_d <= rd;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            end_sim();
        end
    end
    // main sequence
    initial begin
        logic [6:0] ca, cb;
        {rstn, wr, rd, run, lvl, dv, ecs, slp} = 8'h0;
        {addr, wdata, ds, ana} = 35'h0;
        vcc = 12'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        chk(drv, 1'b1);
        rd_reg(REG_STATUS, 8'h00);
        rd_reg(8'h55, 8'h00);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            ca = (i == 0) ? 7'h7f : (i == 1) ? 7'h03 : seed[6:0];
            cb = (i == 0) ? 7'h7f : seed[14:8];
            wr_reg(REG_PARAM_A, {1'b0, ca});
            wr_reg(REG_PARAM_B, {1'b0, cb});
            repeat (3) @(posedge clk);
            chk(res_lin, dec(ca));
            chk(bemf_lin, dec(cb));
            rd_reg(REG_PARAM_A, {1'b0, ca});
        end
        vcc <= seed[27:16];
        ecycle(9'h1ff);
        ecycle(9'h080);
        wr_reg(REG_PARAM_A, 8'h7f);
        wr_reg(REG_NVM_CONTROL, 8'h02);
        wr_reg(REG_DEVICE_CONTROL, PROGRAM_UNLOCK_KEY);
        wr_reg(REG_NVM_CONTROL, 8'h03);
        repeat (3) @(posedge clk);
        chk(busy, 1'b1);
        repeat (30) @(posedge clk);
        chk(busy, 1'b0);
        rd_reg(REG_NVM_CONTROL, 8'h02);
        rd_reg(REG_PARAM_A, 8'h7f);
        wr_reg(REG_PARAM_A, 8'h11);
        repeat (3) @(posedge clk);
        chk(res_lin, 11'd2);
        wr_reg(REG_CONFIG, 8'h02);
        run <= 1'b1;
        repeat (3000) @(posedge clk);
        chk(lp, 1'b0);
        run <= 1'b0;
        repeat (2000) @(posedge clk);
        lvl <= 1'b1;
        repeat (5) @(posedge clk);
        lvl <= 1'b0;
        repeat (2350) @(posedge clk);
        chk(lp, 1'b0);
        wait_lp(1'b1, 100);
        chk(drv, 1'b0);
        chk(buck, 1'b1);
        rd_reg(REG_STATUS, 8'h40);
        wr_reg(REG_CONFIG, 8'h03);
        lvl <= 1'b1;
        repeat (750) @(posedge clk);
        chk(lp, 1'b1);
        wait_lp(1'b0, 100);
        lvl <= 1'b0;
        repeat (3000) @(posedge clk);
        chk(lp, 1'b0);
        // non-zero command first so the zero hold starts at the write below
        wr_reg(REG_SPEED_LO, 8'h05);
        wr_reg(REG_CONFIG, 8'h04);
        wr_reg(REG_SPEED_LO, 8'h00);
        wr_reg(REG_SPEED_HI, 8'h00);
        repeat (2350) @(posedge clk);
        chk(lp, 1'b0);
        wait_lp(1'b1, 100);
        wr_reg(REG_SPEED_LO, 8'h05);
        repeat (750) @(posedge clk);
        chk(lp, 1'b1);
        wait_lp(1'b0, 100);
        slp <= 1'b1;
        ana <= 10'h010;
        wr_reg(REG_CONFIG, 8'h08);
        wait_lp(1'b1, 2200);
        chk({buck, port, drv}, 3'h0);
        rd_reg(REG_STATUS, 8'h00);
        ana <= 10'h040;
        repeat (1000) @(posedge clk);
        chk(lp, 1'b1);
        ana <= 10'h070;
        wait_lp(1'b0, 900);
        repeat (3) @(posedge clk);
        chk(res_lin, 11'd1920);
        rd_reg(REG_CONFIG, 8'h00);
        repeat (3) @(posedge clk);
        end_sim();
    end
endmodule
`default_nettype wire
